// *** verilog/mrg_pkg.sv ***
// constants and state type for the mixer routing and gain register bank
package mrg_pkg;
  localparam int MRG_ADDR_W = 12;
  localparam int MRG_NPATH = 8;
  // register indices; byte address is four times the index
  localparam logic [9:0] MRG_IDX_AUX = 10'h05d;
  localparam logic [9:0] MRG_IDX_LOUT = 10'h060;
  localparam logic [9:0] MRG_IDX_ROUT = 10'h061;
  localparam logic [9:0] MRG_IDX_REC = 10'h062;
  // implemented bits per register
  localparam logic [15:0] MRG_MASK_AUX = 16'h9e07;
  localparam logic [15:0] MRG_MASK_LOUT = 16'h0eee;
  localparam logic [15:0] MRG_MASK_ROUT = 16'he0ee;
  localparam logic [15:0] MRG_MASK_REC = 16'h0e0f;
  localparam logic [15:0] MRG_RST_AUX = 16'h0000;
  localparam logic [15:0] MRG_RST_LOUT = 16'h0000;
  localparam logic [15:0] MRG_RST_ROUT = 16'h0000;
  localparam logic [15:0] MRG_RST_REC = 16'h0000;
  // aux control bit positions, and the record boost bit
  localparam int MRG_AUX_ENA_BIT = 15;
  localparam int MRG_AUX_RCONV_BIT = 12;
  localparam int MRG_AUX_LCONV_BIT = 11;
  localparam int MRG_AUX_ATTN_BIT = 10;
  localparam int MRG_AUX_RREC_BIT = 9;
  localparam int MRG_AUX_SECOND_BIT = 2;
  localparam int MRG_AUX_ROUT_BIT = 1;
  localparam int MRG_AUX_LOUT_BIT = 0;
  localparam int MRG_REC_BOOST_BIT = 0;
  // gain field lsb positions
  localparam int MRG_THIRD_LSB = 9;
  localparam int MRG_THIRD_R_LSB = 13;
  localparam int MRG_RPGA_LSB = 5;
  localparam int MRG_LPGA_LSB = 1;
  localparam int MRG_SECOND_LSB = 1;
  // gain decode: nonzero code n gives base + step*n dB
  localparam logic signed [5:0] MRG_GAIN_BASE_DB = -6'sd15;
  localparam logic signed [5:0] MRG_GAIN_STEP_DB = 6'sd3;
  localparam logic [1:0] MRG_RESP_OKAY = 2'b00;
  localparam logic [1:0] MRG_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic aw_got;
    logic [MRG_ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] aux;
    logic [15:0] lout;
    logic [15:0] rout;
    logic [15:0] rec;
    logic [MRG_NPATH-1:0][5:0] gain_db;
  } mrg_state_t;
endpackage

// *** verilog/mrg_regs.sv ***
// axi4-lite register bank for aux mixer routing and mixer path gains
`timescale 1ns/100ps
module mrg_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [mrg_pkg::MRG_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [mrg_pkg::MRG_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // aux output mixer controls
  output logic aux_mix_enable,
  output logic right_conv_to_aux,
  output logic left_conv_to_aux,
  output logic aux_attenuate,
  output logic right_rec_mix_to_aux,
  output logic right_out_mix_to_aux,
  output logic left_out_mix_to_aux,
  // path gains: raw code, path connected, gain in dB
  output logic [mrg_pkg::MRG_NPATH-1:0][2:0] path_gain_code,
  output logic [mrg_pkg::MRG_NPATH-1:0] path_on,
  output logic [mrg_pkg::MRG_NPATH-1:0][5:0] path_gain_db,
  output logic left_pga_rec_boost
);
  import mrg_pkg::*;

  mrg_state_t st_r;
  mrg_state_t st_nxt;
  logic [9:0] widx;
  logic [9:0] ridx;
  logic [15:0] wmask;
  logic [15:0] wbits;
  logic [31:0] rword;
  logic rhit;
  logic whit;
  logic wcommit;

  // handshake readies straight from state; one write and one read in flight
  assign awready = !st_r.aw_got && !st_r.bvalid;
  assign wready = !st_r.w_got && !st_r.bvalid;
  assign arready = !st_r.rvalid;

  assign widx = st_r.awaddr[11:2];
  assign ridx = araddr[11:2];
  // both write halves held, register update happens this cycle
  assign wcommit = st_r.aw_got && st_r.w_got && !st_r.bvalid;

  // only the low two byte lanes carry register bits
  assign wmask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};

  always_comb begin
    whit = 1'b1;
    wbits = 16'h0000;
    case (widx)
      MRG_IDX_AUX: wbits = MRG_MASK_AUX;
      MRG_IDX_LOUT: wbits = MRG_MASK_LOUT;
      MRG_IDX_ROUT: wbits = MRG_MASK_ROUT;
      MRG_IDX_REC: wbits = MRG_MASK_REC;
      default: whit = 1'b0;
    endcase
  end

  always_comb begin
    rhit = 1'b1;
    rword = 32'h0000_0000;
    case (ridx)
      MRG_IDX_AUX: rword = {16'h0000, st_r.aux & MRG_MASK_AUX};
      MRG_IDX_LOUT: rword = {16'h0000, st_r.lout & MRG_MASK_LOUT};
      MRG_IDX_ROUT: rword = {16'h0000, st_r.rout & MRG_MASK_ROUT};
      MRG_IDX_REC: rword = {16'h0000, st_r.rec & MRG_MASK_REC};
      default: rhit = 1'b0;
    endcase
  end

  // gain code to dB, zero means disconnected
  function automatic logic signed [5:0] gain_of(input logic [2:0] code);
    logic signed [5:0] g;
    g = 6'sd0;
    if (code != 3'b000) begin
      g = 6'(MRG_GAIN_BASE_DB + MRG_GAIN_STEP_DB * $signed({3'b000, code}));
    end
    return g;
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = whit ? MRG_RESP_OKAY : MRG_RESP_SLVERR;
      case (widx)
        MRG_IDX_AUX:
          st_nxt.aux = (st_r.aux & ~(wmask & wbits)) | (st_r.wdata[15:0] & wmask & wbits);
        MRG_IDX_LOUT:
          st_nxt.lout = (st_r.lout & ~(wmask & wbits)) | (st_r.wdata[15:0] & wmask & wbits);
        MRG_IDX_ROUT:
          st_nxt.rout = (st_r.rout & ~(wmask & wbits)) | (st_r.wdata[15:0] & wmask & wbits);
        MRG_IDX_REC:
          st_nxt.rec = (st_r.rec & ~(wmask & wbits)) | (st_r.wdata[15:0] & wmask & wbits);
        default: st_nxt.bresp = MRG_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rword;
      st_nxt.rresp = rhit ? MRG_RESP_OKAY : MRG_RESP_SLVERR;
    end
    // decoded gains follow the codes one cycle later
    for (int i = 0; i < MRG_NPATH; i++) begin
      st_nxt.gain_db[i] = gain_of(path_gain_code[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.aux <= MRG_RST_AUX;
      st_r.lout <= MRG_RST_LOUT;
      st_r.rout <= MRG_RST_ROUT;
      st_r.rec <= MRG_RST_REC;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;

  assign aux_mix_enable = st_r.aux[MRG_AUX_ENA_BIT];
  assign right_conv_to_aux = st_r.aux[MRG_AUX_RCONV_BIT];
  assign left_conv_to_aux = st_r.aux[MRG_AUX_LCONV_BIT];
  assign aux_attenuate = st_r.aux[MRG_AUX_ATTN_BIT];
  assign right_rec_mix_to_aux = st_r.aux[MRG_AUX_RREC_BIT];
  assign right_out_mix_to_aux = st_r.aux[MRG_AUX_ROUT_BIT];
  assign left_out_mix_to_aux = st_r.aux[MRG_AUX_LOUT_BIT];
  assign left_pga_rec_boost = st_r.rec[MRG_REC_BOOST_BIT];

  assign path_gain_code[0] = st_r.lout[MRG_THIRD_LSB +: 3];
  assign path_gain_code[1] = st_r.lout[MRG_RPGA_LSB +: 3];
  assign path_gain_code[2] = st_r.lout[MRG_LPGA_LSB +: 3];
  assign path_gain_code[3] = st_r.rout[MRG_THIRD_R_LSB +: 3];
  assign path_gain_code[4] = st_r.rout[MRG_RPGA_LSB +: 3];
  assign path_gain_code[5] = st_r.rout[MRG_LPGA_LSB +: 3];
  assign path_gain_code[6] = st_r.rec[MRG_THIRD_LSB +: 3];
  assign path_gain_code[7] = st_r.rec[MRG_SECOND_LSB +: 3];

  genvar g;
  generate
    for (g = 0; g < MRG_NPATH; g++) begin : g_path
      assign path_on[g] = path_gain_code[g] != 3'b000;
      assign path_gain_db[g] = st_r.gain_db[g];
    end
  endgenerate

  AST_AUX_ENA: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.aw_got && st_r.w_got && !st_r.bvalid && widx == MRG_IDX_AUX && st_r.wstrb[1])
    |=> aux_mix_enable == $past(st_r.wdata[15]) && bvalid)
    else $error("aux enable not loaded from write");

  AST_ATTN: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.aw_got && st_r.w_got && !st_r.bvalid && widx == MRG_IDX_AUX && st_r.wstrb[1])
    |=> aux_attenuate == $past(st_r.wdata[10]))
    else $error("attenuate bit not loaded from write");

  AST_OUT_LSB: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.aw_got && st_r.w_got && !st_r.bvalid && widx == MRG_IDX_AUX && st_r.wstrb[0])
    |=> left_out_mix_to_aux == $past(st_r.wdata[0]))
    else $error("left output mixer route not loaded");

  AST_GAIN_DEC: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ($past(path_gain_code[0]) == 3'b111) |-> $signed(path_gain_db[0]) == 6'sd6)
    else $error("code 111 does not decode to +6dB");

  AST_GAIN_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ($past(path_gain_code[4]) == 3'b011) |-> $signed(path_gain_db[4]) == -6'sd6)
    else $error("code 011 does not decode to -6dB");

  AST_RESET_ZERO: assert property (@(posedge aclk)
    $rose(aresetn) |-> path_on == '0 && !left_pga_rec_boost && !aux_mix_enable)
    else $error("paths not disconnected after reset");

  AST_RSVD_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && ridx == MRG_IDX_LOUT)
    |=> rvalid && (rdata & ~{16'h0000, MRG_MASK_LOUT}) == 32'h0000_0000)
    else $error("undescribed bits read nonzero");

  AST_READBACK: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && ridx == MRG_IDX_REC)
    |=> rdata[3:1] == $past(path_gain_code[7]))
    else $error("second left gain readback mismatch");

  AST_WRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    (awvalid && awready && wvalid && wready) |=> ##1 bvalid)
    else $error("write response late");

  AST_RCONV: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_AUX && st_r.wstrb[1])
    |=> right_conv_to_aux == $past(st_r.wdata[12]))
    else $error("right converter route not loaded");

  AST_LCONV: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_AUX && st_r.wstrb[1])
    |=> left_conv_to_aux == $past(st_r.wdata[11]))
    else $error("left converter route not loaded");

  AST_RREC: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_AUX && st_r.wstrb[1])
    |=> right_rec_mix_to_aux == $past(st_r.wdata[9]))
    else $error("right record mixer route not loaded");

  AST_ROUT_AUX: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_AUX && st_r.wstrb[0])
    |=> right_out_mix_to_aux == $past(st_r.wdata[1]))
    else $error("right output mixer route not loaded");

  AST_AUX_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wcommit && widx == MRG_IDX_AUX) |=> $stable(aux_mix_enable))
    else $error("aux enable changed without a write");

  AST_GAIN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (path_gain_code[1] == 3'b000) |-> !path_on[1])
    else $error("code 000 does not disconnect the path");

  AST_GAIN_M12: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(path_gain_code[2]) == 3'b001) |-> $signed(path_gain_db[2]) == -6'sd12)
    else $error("code 001 does not decode to -12dB");

  AST_GAIN_M9: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(path_gain_code[5]) == 3'b010) |-> $signed(path_gain_db[5]) == -6'sd9)
    else $error("code 010 does not decode to -9dB");

  AST_GAIN_P3: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(path_gain_code[3]) == 3'b110) |-> $signed(path_gain_db[3]) == 6'sd3)
    else $error("code 110 does not decode to +3dB");

  AST_LOUT_THIRD: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_LOUT && st_r.wstrb[1])
    |=> path_gain_code[0] == $past(st_r.wdata[11:9]))
    else $error("left out third left gain not loaded");

  AST_LOUT_RPGA: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_LOUT && st_r.wstrb[0])
    |=> path_gain_code[1] == $past(st_r.wdata[7:5]))
    else $error("left out right amplifier gain not loaded");

  AST_LOUT_LPGA: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_LOUT && st_r.wstrb[0])
    |=> path_gain_code[2] == $past(st_r.wdata[3:1]))
    else $error("left out left amplifier gain not loaded");

  AST_ROUT_THIRD: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_ROUT && st_r.wstrb[1])
    |=> path_gain_code[3] == $past(st_r.wdata[15:13]))
    else $error("right out third right gain not loaded");

  AST_ROUT_RPGA: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_ROUT && st_r.wstrb[0])
    |=> path_gain_code[4] == $past(st_r.wdata[7:5]))
    else $error("right out right amplifier gain not loaded");

  AST_ROUT_LPGA: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_ROUT && st_r.wstrb[0])
    |=> path_gain_code[5] == $past(st_r.wdata[3:1]))
    else $error("right out left amplifier gain not loaded");

  AST_REC_THIRD: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_REC && st_r.wstrb[1])
    |=> path_gain_code[6] == $past(st_r.wdata[11:9]))
    else $error("record third left gain not loaded");

  AST_REC_SECOND: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_REC && st_r.wstrb[0])
    |=> path_gain_code[7] == $past(st_r.wdata[3:1]))
    else $error("record second left gain not loaded");

  AST_BOOST: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && widx == MRG_IDX_REC && st_r.wstrb[0])
    |=> left_pga_rec_boost == $past(st_r.wdata[0]))
    else $error("record boost bit not loaded");

  AST_RESET_REGS: assert property (@(posedge aclk)
    $rose(aresetn) |-> path_gain_code == '0 && path_gain_db == '0)
    else $error("gain fields not cleared by reset");

  AST_WR_UNMAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (wcommit && !whit) |=> bvalid && bresp == MRG_RESP_SLVERR)
    else $error("unmapped write not refused");

  AST_RD_UNMAP: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && !rhit)
    |=> rvalid && rresp == MRG_RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  AST_RD_UPPER: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  AST_RVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped before taken");

  AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write answer dropped before taken");
endmodule

// *** bench/mrg_regs_test.sv ***
// self-checking testbench for the mixer routing and gain register bank
`timescale 1ns/100ps
module mrg_regs_test;
  import mrg_pkg::*;
  localparam logic [3:0][11:0] ADR = {{MRG_IDX_REC, 2'b00}, {MRG_IDX_ROUT, 2'b00},
    {MRG_IDX_LOUT, 2'b00}, {MRG_IDX_AUX, 2'b00}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, boost;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] aux_o;
  logic [7:0][2:0] code;
  logic [7:0] path_on;
  logic [7:0][5:0] db;
  int errors = 0, n_tests = 0, cycles = 0;

  mrg_regs i_mrg_regs (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .aux_mix_enable(aux_o[6]), .right_conv_to_aux(aux_o[5]), .left_conv_to_aux(aux_o[4]),
    .aux_attenuate(aux_o[3]), .right_rec_mix_to_aux(aux_o[2]),
    .right_out_mix_to_aux(aux_o[1]), .left_out_mix_to_aux(aux_o[0]),
    .path_gain_code(code), .path_on(path_on), .path_gain_db(db),
    .left_pga_rec_boost(boost));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("errors %0d, checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hang fails the run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ready is sampled before the edge's own updates land
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    check(32'(aux_o), 32'h0000_0000);
    check(32'(path_on), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      rd(ADR[i], d, r);
      check(d, 32'h0000_0000);
    end
  endtask

  task automatic t_aux();
    int bits[7] = '{15, 12, 11, 10, 9, 1, 0};
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 7; k++) begin
      wr(ADR[0], 16'h0001 << bits[k], 4'b0011, r);
      check(32'(aux_o), 32'(7'h40 >> k));
    end
    wr(ADR[0], 16'hfffb, 4'b0011, r);
    check(32'(aux_o), 32'h0000_007f);
    rd(ADR[0], d, r);
    check(d, 32'h0000_9e03);
    // only the upper byte lane is written here
    wr(ADR[0], 16'h0000, 4'b0010, r);
    rd(ADR[0], d, r);
    check(d, 32'h0000_0003);
    check(32'(aux_o), 32'h0000_0003);
  endtask

  task automatic t_gain();
    logic [2:0] c [8];
    logic [15:0] v [4];
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 8; n++) begin
      for (int p = 0; p < 8; p++) c[p] = 3'(n + p);
      v[1] = {4'h0, c[0], 1'b0, c[1], 1'b0, c[2], 1'b0};
      v[2] = {c[3], 5'h00, c[4], 1'b0, c[5], 1'b0};
      v[3] = {4'h0, c[6], 5'h00, c[7], n[0]};
      for (int i = 1; i < 4; i++) wr(ADR[i], v[i], 4'b0011, r);
      for (int p = 0; p < 8; p++) begin
        check(32'(code[p]), 32'(c[p]));
        check(32'(path_on[p]), 32'(c[p] != 3'h0));
        check(32'(db[p]), 32'(c[p] == 3'h0 ? 6'h00 : 6'(3 * c[p] - 15)));
      end
      check(32'(boost), 32'(n[0]));
      for (int i = 1; i < 4; i++) begin
        rd(ADR[i], d, r);
        check(d, {16'h0000, v[i]});
      end
    end
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    wr(12'h190, 16'hffff, 4'b0011, r);
    check(32'(r), 32'(MRG_RESP_SLVERR));
    rd(12'h190, d, r);
    check(d, 32'h0000_0000);
    check(32'(r), 32'(MRG_RESP_SLVERR));
    rd(ADR[0], d, r);
    check(d, 32'h0000_0003);
    check(32'(r), 32'(MRG_RESP_OKAY));
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_aux();
    t_gain();
    t_unmapped();
    conclude();
  end
endmodule
